// file: design/aer_pkg.sv
// Package of constants and types for the extended adjustment register bank.
package aer_pkg;

  // ----------------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W      = 4;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned HEADER_W    = 12;
  localparam logic [11:0] HEADER_PAT  = 12'h001;
  localparam int unsigned FRAME_W     = HEADER_W + ADDR_W + DATA_W;
  localparam logic [5:0]  FRAME_BITS  = 6'h20;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_I_OFFSET  = 4'h2;
  localparam logic [3:0] ADDR_I_GAIN    = 4'h3;
  localparam logic [3:0] ADDR_EXT_CFG   = 4'h9;
  localparam logic [3:0] ADDR_Q_OFFSET  = 4'ha;
  localparam logic [3:0] ADDR_Q_GAIN    = 4'hb;
  localparam logic [3:0] ADDR_FINE      = 4'he;
  localparam logic [3:0] ADDR_COARSE    = 4'hf;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] RST_OFFSET  = 16'h007f;
  localparam logic [15:0] RST_GAIN    = 16'h807f;
  localparam logic [15:0] RST_EXT_CFG = 16'h03ff;
  localparam logic [15:0] RST_FINE    = 16'h00ff;
  localparam logic [15:0] RST_COARSE  = 16'h007f;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned OFS_MAG_HI  = 15;
  localparam int unsigned OFS_MAG_LO  = 8;
  localparam int unsigned OFS_SIGN    = 7;
  localparam int unsigned GAIN_HI     = 15;
  localparam int unsigned GAIN_LO     = 7;
  localparam int unsigned EXT_PATTERN = 15;
  localparam int unsigned EXT_TRIM    = 14;
  localparam int unsigned EXT_DES     = 13;
  localparam int unsigned EXT_SOURCE  = 12;
  localparam int unsigned EXT_SLOW    = 10;
  localparam int unsigned FINE_HI     = 15;
  localparam int unsigned FINE_LO     = 8;
  localparam int unsigned CRS_INV     = 15;
  localparam int unsigned CRS_HI      = 14;
  localparam int unsigned CRS_LO      = 10;
  localparam int unsigned MID_HI      = 9;
  localparam int unsigned MID_LO      = 7;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] magnitude;
    logic       negative;
  } aer_offset_s;

  typedef struct packed {
    logic patternOutputEnable;
    logic terminationTrimSkip;
    logic dualEdgeSampling;
    logic inputSourceSelect;
    logic slowClockTuning;
  } aer_ext_cfg_s;

  typedef struct packed {
    logic       sampleClockInvert;
    logic [4:0] coarseDelay;
    logic [2:0] intermediateDelay;
    logic [7:0] fineDelay;
  } aer_phase_s;

  typedef enum logic [1:0] {
    AER_IDLE  = 2'b00,
    AER_SHIFT = 2'b01,
    AER_DONE  = 2'b11
  } aer_state_e;

endpackage

// file: design/aer_extended_adjust_regs.sv
// Extended adjustment register bank with its serial configuration port.
`timescale 1ns/10ps
`default_nettype none

module aer_extended_adjust_regs
  import aer_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic         serialClk,
  input  wire logic         serialSelect_n,
  input  wire logic         serialData,
  input  wire logic         extendedMode,
  input  wire logic         calibrationRunning,
  output logic              writeStrobe,
  output aer_offset_s       iOffset,
  output aer_offset_s       qOffset,
  output logic [8:0]        iGainCode,
  output logic [8:0]        qGainCode,
  output aer_ext_cfg_s      extCfg,
  output aer_phase_s        phase
);

  // ----------------------------------------------------------------------
  // Serial receiver
  // ----------------------------------------------------------------------
  // The serial clock is sampled as an ordinary input; its rising edge
  // shifts one bit. Frames shorter than the full length are discarded.
  aer_state_e          state_r, state_nxt;
  logic [FRAME_W-1:0]  shift_r, shift_nxt;
  logic [5:0]          count_r, count_nxt;
  logic                sclkPrev_r;
  logic                sclkRise;

  assign sclkRise = serialClk & ~sclkPrev_r;

  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    count_nxt = count_r;
    case (state_r)
      AER_IDLE: begin
        count_nxt = 6'h00;
        if (!serialSelect_n) begin
          state_nxt = AER_SHIFT;
        end
      end
      AER_SHIFT: begin
        if (serialSelect_n) begin
          state_nxt = AER_IDLE;
        end else if (sclkRise) begin
          shift_nxt = {shift_r[FRAME_W-2:0], serialData};
          count_nxt = count_r + 6'h01;
          if (count_r == FRAME_BITS - 6'h01) begin
            state_nxt = AER_DONE;
          end
        end
      end
      AER_DONE: begin
        if (serialSelect_n) begin
          state_nxt = AER_IDLE;
        end
      end
      default: begin
        state_nxt = AER_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r    <= AER_IDLE;
      shift_r    <= '0;
      count_r    <= 6'h00;
      sclkPrev_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      shift_r    <= shift_nxt;
      count_r    <= count_nxt;
      sclkPrev_r <= serialClk;
    end
  end

  // ----------------------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------------------
  logic              frameDone;
  logic [3:0]        frameAddr;
  logic [15:0]       frameData;

  // A full frame is committed once, on entry to the done state.
  assign frameDone = (state_r == AER_SHIFT) && (state_nxt == AER_DONE)
                     && (shift_nxt[FRAME_W-1 -: HEADER_W] == HEADER_PAT);
  assign frameAddr = shift_nxt[DATA_W +: ADDR_W];
  assign frameData = shift_nxt[DATA_W-1:0];

  function automatic logic hit(input logic [3:0] a);
    hit = frameDone && (frameAddr == a);
  endfunction

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  // Writes during calibration are not blocked; the host is trusted to
  // hold off, and blocking would hide its mistake.
  logic [15:0] iOfs_r, iOfs_nxt;
  logic [15:0] iGain_r, iGain_nxt;
  logic [15:0] ext_r, ext_nxt;
  logic [15:0] qOfs_r, qOfs_nxt;
  logic [15:0] qGain_r, qGain_nxt;
  logic [15:0] fine_r, fine_nxt;
  logic [15:0] coarse_r, coarse_nxt;
  logic        strobe_nxt;

  always_comb begin
    iOfs_nxt   = hit(ADDR_I_OFFSET) ? frameData : iOfs_r;
    iGain_nxt  = hit(ADDR_I_GAIN)   ? frameData : iGain_r;
    ext_nxt    = hit(ADDR_EXT_CFG)  ? frameData : ext_r;
    qOfs_nxt   = hit(ADDR_Q_OFFSET) ? frameData : qOfs_r;
    qGain_nxt  = hit(ADDR_Q_GAIN)   ? frameData : qGain_r;
    fine_nxt   = hit(ADDR_FINE)     ? frameData : fine_r;
    coarse_nxt = hit(ADDR_COARSE)   ? frameData : coarse_r;
    strobe_nxt = frameDone;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      iOfs_r      <= RST_OFFSET;
      iGain_r     <= RST_GAIN;
      ext_r       <= RST_EXT_CFG;
      qOfs_r      <= RST_OFFSET;
      qGain_r     <= RST_GAIN;
      fine_r      <= RST_FINE;
      coarse_r    <= RST_COARSE;
      writeStrobe <= 1'b0;
    end else begin
      iOfs_r      <= iOfs_nxt;
      iGain_r     <= iGain_nxt;
      ext_r       <= ext_nxt;
      qOfs_r      <= qOfs_nxt;
      qGain_r     <= qGain_nxt;
      fine_r      <= fine_nxt;
      coarse_r    <= coarse_nxt;
      writeStrobe <= strobe_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Effective controls
  // ----------------------------------------------------------------------
  // Outside extended mode every control falls back to its reset meaning.
  // Gain reaches the analog side straight from the register, so no
  // calibration handshake is involved in a gain change.
  aer_offset_s   iOffset_nxt, qOffset_nxt;
  aer_ext_cfg_s  extCfg_nxt;
  aer_phase_s    phase_nxt;
  logic [8:0]    iGain_eff, qGain_eff;
  logic [15:0]   iOfsSel, qOfsSel, iGainSel, qGainSel;
  logic [15:0]   extSel, fineSel, coarseSel;

  always_comb begin
    iOfsSel   = extendedMode ? iOfs_r   : RST_OFFSET;
    qOfsSel   = extendedMode ? qOfs_r   : RST_OFFSET;
    iGainSel  = extendedMode ? iGain_r  : RST_GAIN;
    qGainSel  = extendedMode ? qGain_r  : RST_GAIN;
    extSel    = extendedMode ? ext_r    : RST_EXT_CFG;
    fineSel   = extendedMode ? fine_r   : RST_FINE;
    coarseSel = extendedMode ? coarse_r : RST_COARSE;

    iOffset_nxt.magnitude = iOfsSel[OFS_MAG_HI:OFS_MAG_LO];
    iOffset_nxt.negative  = iOfsSel[OFS_SIGN];
    qOffset_nxt.magnitude = qOfsSel[OFS_MAG_HI:OFS_MAG_LO];
    qOffset_nxt.negative  = qOfsSel[OFS_SIGN];

    iGain_eff = iGainSel[GAIN_HI:GAIN_LO];
    qGain_eff = qGainSel[GAIN_HI:GAIN_LO];

    extCfg_nxt.patternOutputEnable = extSel[EXT_PATTERN];
    extCfg_nxt.terminationTrimSkip = extSel[EXT_TRIM];
    extCfg_nxt.dualEdgeSampling    = extSel[EXT_DES];
    extCfg_nxt.inputSourceSelect   = extSel[EXT_SOURCE];
    extCfg_nxt.slowClockTuning     = extSel[EXT_SLOW];

    phase_nxt.fineDelay         = fineSel[FINE_HI:FINE_LO];
    phase_nxt.sampleClockInvert = coarseSel[CRS_INV];
    phase_nxt.coarseDelay       = coarseSel[CRS_HI:CRS_LO];
    phase_nxt.intermediateDelay = coarseSel[MID_HI:MID_LO];
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      iOffset   <= '0;
      qOffset   <= '0;
      iGainCode <= RST_GAIN[GAIN_HI:GAIN_LO];
      qGainCode <= RST_GAIN[GAIN_HI:GAIN_LO];
      extCfg    <= '0;
      phase     <= '0;
    end else begin
      iOffset   <= iOffset_nxt;
      qOffset   <= qOffset_nxt;
      iGainCode <= iGain_eff;
      qGainCode <= qGain_eff;
      extCfg    <= extCfg_nxt;
      phase     <= phase_nxt;
    end
  end

  // The calibration flag is only observed by the host side.
  logic unusedCal;
  assign unusedCal = calibrationRunning;

endmodule

`default_nettype wire

// file: tb/aer_extended_adjust_regs_properties.sv
// Port checker for the extended adjustment register bank.
`timescale 1ns/10ps
`default_nettype none
module aer_regs_checker
  import aer_pkg::*;
(
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        serialSelect_n,
  input wire logic        extendedMode,
  input wire logic        writeStrobe,
  input wire aer_offset_s iOffset,
  input wire aer_offset_s qOffset,
  input wire logic [8:0]  iGainCode,
  input wire logic [8:0]  qGainCode,
  input wire aer_ext_cfg_s extCfg,
  input wire aer_phase_s  phase
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // A commit needs the select low, so two idle cycles forbid a strobe.
  sequence seqIdle;
    serialSelect_n [*2];
  endsequence
  sequence seqModeHeld;
    extendedMode [*3];
  endsequence
  AST_STROBE_PULSE: assert property (writeStrobe |=> !writeStrobe)
    else $error("write strobe wider than one cycle");
  AST_STROBE_IN_FRAME: assert property (seqIdle |=> !writeStrobe)
    else $error("write strobe without a selected frame");
  AST_NORMAL_OFFSET: assert property (
    !extendedMode |=> iOffset == 9'h000 && qOffset == 9'h000)
    else $error("offset active in normal mode");
  AST_NORMAL_GAIN: assert property (
    !extendedMode |=> iGainCode == 9'h100 && qGainCode == 9'h100)
    else $error("gain adjusted in normal mode");
  AST_NORMAL_CFG: assert property (!extendedMode |=> extCfg == 5'h00)
    else $error("feature active in normal mode");
  AST_NORMAL_PHASE: assert property (!extendedMode |=> phase == 17'h0)
    else $error("phase adjusted in normal mode");
  // Outputs are registered from the register file, so they move one cycle
  // after the strobe; the strobe is therefore looked at one cycle back.
  AST_HOLD_CFG: assert property (
    seqModeHeld ##0 !$past(writeStrobe)
      |-> $stable(extCfg) && $stable(phase))
    else $error("config changed without a write");
  AST_HOLD_ADJ: assert property (
    seqModeHeld ##0 !$past(writeStrobe)
      |-> $stable({iOffset, qOffset, iGainCode, qGainCode}))
    else $error("adjustment changed without a write");
endmodule
`default_nettype wire

// file: tb/aer_host_model.sv
// Host model that shifts configuration frames into the serial port.
`timescale 1ns/10ps
`default_nettype none
module aer_host_model (
  input  wire logic        mclk,
  input  wire logic        go,
  input  wire logic [31:0] frame,
  input  wire logic [5:0]  nBits,
  output logic             serialClk,
  output logic             serialSelect_n,
  output logic             serialData,
  output logic             busy
);
  logic [1:0] ph;
  logic [5:0] cnt;
  initial begin
    serialClk = 1'b0;
    serialSelect_n = 1'b1;
    serialData = 1'b0;
    busy = 1'b0;
    ph = 2'h0;
    cnt = 6'h00;
  end
  // Four cycles a bit; a quiet bit time follows so select outlasts sync.
  always @(posedge mclk) begin
    if (!busy) begin
      if (go) begin
        busy <= 1'b1;
        serialSelect_n <= 1'b0;
        cnt <= 6'h00;
        ph <= 2'h0;
      end
    end else begin
      ph <= ph + 2'h1;
      if (ph == 2'h0 && cnt < nBits) serialData <= frame[~cnt[4:0]];
      if (ph == 2'h1 && cnt < nBits) serialClk <= 1'b1;
      if (ph == 2'h3) begin
        serialClk <= 1'b0;
        cnt <= cnt + 6'h01;
        if (cnt == nBits) begin
          busy <= 1'b0;
          serialSelect_n <= 1'b1;
          serialData <= ~serialData;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/test_aer_extended_adjust_regs.sv
// Self-checking bench for the extended adjustment register bank.
`timescale 1ns/10ps
`default_nettype none
module test_aer_extended_adjust_regs
  import aer_pkg::*;
;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic mode = 1'b1;
  logic go = 1'b0;
  logic [31:0] frame = 32'h0;
  logic [5:0] nBits = 6'h20;
  logic sClk, sSel_n, sData, busy, strobe;
  aer_offset_s iOfs, qOfs, eIo, eQo;
  logic [8:0] iGain, qGain, eIg, eQg;
  aer_ext_cfg_s cfg, eC;
  aer_phase_s ph, eP;
  logic [57:0] outV;
  logic [15:0] cfgTab [5] = '{16'h83ff, 16'h43ff, 16'h23ff, 16'h13ff,
                              16'h07ff};
  int badCount = 0;
  int compares = 0;
  int cycles = 0;
  int strobes = 0;
  assign outV = {iOfs, qOfs, iGain, qGain, cfg, ph};
  aer_extended_adjust_regs dut (.mclk(mclk), .nrst(nrst), .serialClk(sClk),
    .serialSelect_n(sSel_n), .serialData(sData), .extendedMode(mode),
    .calibrationRunning(1'b0), .writeStrobe(strobe), .iOffset(iOfs),
    .qOffset(qOfs), .iGainCode(iGain), .qGainCode(qGain), .extCfg(cfg),
    .phase(ph));
  aer_host_model host (.mclk(mclk), .go(go), .frame(frame), .nBits(nBits),
    .serialClk(sClk), .serialSelect_n(sSel_n), .serialData(sData),
    .busy(busy));
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (strobe === 1'b1) strobes <= strobes + 1;
    if (cycles == 8000) begin
      badCount = badCount + 1;
      wrapUp();
    end
  end
  task automatic wrapUp();
    $display("compares %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [57:0] got, input logic [57:0] exp);
    compares++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One frame of nb bits; es is the number of write strobes it should raise.
  task automatic send(input logic [11:0] hdr, input logic [3:0] adr,
                      input logic [15:0] dat, input logic [5:0] nb,
                      input int es);
    int s0;
    s0 = strobes;
    @(posedge mclk);
    frame <= {hdr, adr, dat};
    nBits <= nb;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    @(negedge mclk);
    for (int n = 0; n < 300 && busy === 1'b1; n++) @(negedge mclk);
    repeat (4) @(negedge mclk);
    cmp(58'(strobes - s0), 58'(es));
  endtask
  task automatic look(input logic ext);
    repeat (2) @(negedge mclk);
    if (ext) cmp(outV, {eIo, eQo, eIg, eQg, eC, eP});
    else cmp(outV, {18'h0, 9'h100, 9'h100, 22'h0});
  endtask
  initial begin
    eIo = '0;
    eQo = '0;
    eIg = 9'h100;
    eQg = 9'h100;
    eC = '0;
    eP = '0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    look(1'b1);
    send(HEADER_PAT, ADDR_I_OFFSET, 16'hffff, 6'h20, 1);
    send(HEADER_PAT, ADDR_Q_OFFSET, 16'h00ff, 6'h20, 1);
    eIo = '{8'hff, 1'b1};
    eQo = '{8'h00, 1'b1};
    look(1'b1);
    send(HEADER_PAT, ADDR_I_GAIN, {9'h0c0, 7'h7f}, 6'h20, 1);
    send(HEADER_PAT, ADDR_Q_GAIN, {9'h1c0, 7'h7f}, 6'h20, 1);
    eIg = 9'h0c0;
    eQg = 9'h1c0;
    look(1'b1);
    for (int b = 0; b < 5; b++) begin
      send(HEADER_PAT, ADDR_EXT_CFG, cfgTab[b], 6'h20, 1);
      eC = 5'h10 >> b;
      look(1'b1);
    end
    send(12'h002, ADDR_EXT_CFG, 16'h83ff, 6'h20, 0);
    send(HEADER_PAT, ADDR_EXT_CFG, 16'h83ff, 6'h1f, 0);
    send(HEADER_PAT, 4'h4, 16'h83ff, 6'h20, 1);
    look(1'b1);
    send(HEADER_PAT, ADDR_FINE, 16'h5aff, 6'h20, 1);
    send(HEADER_PAT, ADDR_COARSE, 16'hd2ff, 6'h20, 1);
    eP = '{1'b1, 5'h14, 3'h5, 8'h5a};
    look(1'b1);
    @(posedge mclk);
    mode <= 1'b0;
    send(HEADER_PAT, ADDR_Q_GAIN, {9'h140, 7'h7f}, 6'h20, 1);
    look(1'b0);
    @(posedge mclk);
    mode <= 1'b1;
    eQg = 9'h140;
    look(1'b1);
    wrapUp();
  end
endmodule
bind aer_extended_adjust_regs aer_regs_checker chk (.mclk(mclk),
  .nrst(nrst), .serialSelect_n(serialSelect_n), .extendedMode(extendedMode),
  .writeStrobe(writeStrobe), .iOffset(iOffset), .qOffset(qOffset),
  .iGainCode(iGainCode), .qGainCode(qGainCode), .extCfg(extCfg),
  .phase(phase));
`default_nettype wire
